/* File: hw/crypt_key_gen.v */
`timescale 1ns/100ps
`include "flash_crypt_map.vh"
// address-tweaked key derivation, purely combinational, one copy per user port
module crypt_key_gen (
   input wire [`KEY_W-1:0] base_key,
   input wire [`CFG_W-1:0] crypt_cfg,
   input wire [`ADDR_W-1:0] addr,
   output reg [`WORD_W-1:0] word_key
);
   reg [`WORD_W-1:0] tweak;
   integer i;
   // with crypt_cfg zero the address is masked out, else each block gets its own key
   always @* begin
      tweak = {`WORD_W{1'b0}};
      if (crypt_cfg != {`CFG_W{1'b0}}) begin
         tweak = {{(`WORD_W-`ADDR_W+`BLK_LSB){1'b0}}, addr[`ADDR_W-1:`BLK_LSB]};
         tweak = (tweak ^ {28'h0000000, crypt_cfg}) * `MIX_A;
      end
      word_key = `MIX_B;
      for (i = 0; i < `BLK_WORDS; i = i + 1) begin
         word_key = (word_key ^ base_key[i*`WORD_W +: `WORD_W]) + tweak;
         word_key = {word_key[26:0], word_key[31:27]};
      end
   end
endmodule // crypt_key_gen

/* File: hw/flash_crypt_control.v */
`timescale 1ns/100ps
`include "flash_crypt_map.vh"
// Functional notes
// - fetch six fuse parameters
// - base key from coding scheme, key fuses
// - per-path keys from base, config, address
// - zero config: keys ignore address
// - nonzero config: key per eight-word block
// - two key generators, one per path, both paths concurrent
// - encrypt buffer with address key, then done
// - completed encryption replaces write data in its block
// - otherwise write data passes unchanged
// - encrypt gating by enable and boot mode
// - no software read of ciphertext, key
// - decrypt path has no software registers
// - cache reads decrypted transparently
// - flash boot: odd ones decrypts
// - download boot: enable and not disabled
// - inactive decrypt returns raw data
// - buffers, start, address write-only; done read-only
module flash_crypt_control #(
   parameter ROUNDS = `ROUNDS
) (
   input wire clk,
   input wire rstn,
   // fuse parameters and boot mode
   input wire [`CODING_W-1:0] coding_scheme,
   input wire [`KEY_W-1:0] key_fuse_block,
   input wire [`CFG_W-1:0] flash_crypt_config,
   input wire download_dis_encrypt,
   input wire download_dis_decrypt,
   input wire [`CNT_W-1:0] flash_crypt_cnt,
   input wire download_boot,
   // flash_crypt_config_register bits
   input wire encrypt_path_enable,
   input wire decrypt_path_enable,
   // software side: write-only controls, read-only done
   input wire buf_we,
   input wire [`BLK_IDX_W-1:0] buf_idx,
   input wire [`WORD_W-1:0] buf_wdata,
   input wire addr_we,
   input wire [`ADDR_W-1:0] addr_wdata,
   input wire start,
   output reg done,
   // flash_spi_controller write port
   input wire wr_req,
   input wire [`ADDR_W-1:0] wr_addr,
   input wire [`BLK_IDX_W-1:0] wr_idx,
   input wire [`WORD_W-1:0] wr_plain,
   output reg [`WORD_W-1:0] wr_data,
   output reg wr_valid,
   // cache read port
   input wire rd_req,
   input wire [`ADDR_W-1:0] rd_addr,
   input wire [`WORD_W-1:0] rd_raw,
   output reg [`WORD_W-1:0] rd_data,
   output reg rd_valid
);
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_DONE = 2'b10;

   // one keyed round for the engine; dec_round inverts it for the decrypt path
   function [`WORD_W-1:0] enc_round;
      input [`WORD_W-1:0] w;
      input [`WORD_W-1:0] k;
      begin
         enc_round = {w[28:0], w[31:29]} + k;
      end
   endfunction
   function [`WORD_W-1:0] dec_round;
      input [`WORD_W-1:0] w;
      input [`WORD_W-1:0] k;
      reg [`WORD_W-1:0] t;
      begin
         t = w - k;
         dec_round = {t[2:0], t[31:3]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // key generator
   reg [`KEY_W-1:0] base_key;
   wire [`WORD_W-1:0] key_e;
   wire [`WORD_W-1:0] key_d;
   reg [`ADDR_W-1:0] enc_addr_q;
   // base key folds the coding scheme into the fuse key
   always @* begin
      base_key = key_fuse_block ^ {{(`KEY_W-`CODING_W){1'b0}}, coding_scheme};
   end
   // two generator copies, one per address, so both paths run at once
   crypt_key_gen u_key_e (
      .base_key(base_key),
      .crypt_cfg(flash_crypt_config),
      .addr(enc_addr_q),
      .word_key(key_e)
   );
   crypt_key_gen u_key_d (
      .base_key(base_key),
      .crypt_cfg(flash_crypt_config),
      .addr(rd_addr),
      .word_key(key_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   // operating conditions
   wire enc_op;
   wire dec_op;
   assign enc_op = encrypt_path_enable & (~download_boot | ~download_dis_encrypt);
   assign dec_op = download_boot ? (decrypt_path_enable & ~download_dis_decrypt)
      : ^flash_crypt_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // encryption engine; buffers, address and result have no read path
   reg [`WORD_W-1:0] buf_q [0:`BLK_WORDS-1];
   reg [1:0] st_q;
   reg [`ROUND_W-1:0] rnd_q;
   reg res_ok_q;
   integer j;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (j = 0; j < `BLK_WORDS; j = j + 1) begin
            buf_q[j] <= {`WORD_W{1'b0}};
         end
         enc_addr_q <= {`ADDR_W{1'b0}};
         st_q <= ST_IDLE;
         rnd_q <= {`ROUND_W{1'b0}};
         done <= 1'b0;
         res_ok_q <= 1'b0;
      end else begin
         if (addr_we) begin
            enc_addr_q <= addr_wdata;
            res_ok_q <= 1'b0;
         end
         if (buf_we && st_q != ST_RUN) begin
            buf_q[buf_idx] <= buf_wdata;
            res_ok_q <= 1'b0;
         end
         case (st_q)
            ST_IDLE, ST_DONE: begin
               if (start && enc_op) begin
                  done <= 1'b0;
                  res_ok_q <= 1'b0;
                  rnd_q <= {`ROUND_W{1'b0}};
                  st_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               // all eight words step one round per cycle with the address key
               for (j = 0; j < `BLK_WORDS; j = j + 1) begin
                  buf_q[j] <= enc_round(buf_q[j], key_e ^ j);
               end
               if (rnd_q == ROUNDS[`ROUND_W-1:0] - 1'b1) begin
                  done <= 1'b1;
                  res_ok_q <= 1'b1;
                  st_q <= ST_DONE;
               end else begin
                  rnd_q <= rnd_q + 1'b1;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         if (!enc_op) begin
            res_ok_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flash write substitution, one cycle per word
   wire blk_hit;
   assign blk_hit = res_ok_q && enc_op &&
      (wr_addr[`ADDR_W-1:`BLK_LSB] == enc_addr_q[`ADDR_W-1:`BLK_LSB]);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_data <= {`WORD_W{1'b0}};
         wr_valid <= 1'b0;
      end else begin
         wr_valid <= wr_req;
         if (wr_req) begin
            wr_data <= blk_hit ? buf_q[wr_idx] : wr_plain;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transparent cache decryption, one cycle latency
   reg [`WORD_W-1:0] dec_w;
   integer r;
   always @* begin
      dec_w = rd_raw;
      for (r = 0; r < ROUNDS; r = r + 1) begin
         dec_w = dec_round(dec_w, key_d ^ {29'h00000000, rd_addr[4:2]});
      end
   end
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= {`WORD_W{1'b0}};
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            rd_data <= dec_op ? dec_w : rd_raw;
         end
      end
   end
endmodule // flash_crypt_control

/* File: hw/flash_crypt_map.vh */
`ifndef FLASH_CRYPT_MAP_VH
`define FLASH_CRYPT_MAP_VH
// widths of the fuse parameters and the block geometry
`define CODING_W 2
`define KEY_W 256
`define CFG_W 4
`define CNT_W 7
`define ADDR_W 24
`define WORD_W 32
`define BLK_WORDS 8
`define BLK_IDX_W 3
// byte offset bits inside one aligned eight-word block
`define BLK_LSB 5
// engine rounds per block
`define ROUNDS 8
`define ROUND_W 4
// mixing constants, arbitrary values
`define MIX_A 32'h9E3779B9
`define MIX_B 32'h7F4A7C15
`endif

/* File: verif/flash_array_model.sv */
`timescale 1ns/100ps
// flash array: keeps the words the block hands over
module flash_array_model (
   input wire logic clk, wr_req, wr_valid,
   input wire logic [2:0] wr_idx,
   input wire logic [23:0] wr_addr, rd_addr,
   input wire logic [31:0] wr_data,
   output logic [31:0] rd_raw
);
   logic [31:0] mem_q [256] = '{default: 32'hA55A5AA5};
   logic [7:0] slot_q = 8'h00;
   // slot of the pending word, filled when the block answers
   always @(posedge clk) begin
      if (wr_req)
         slot_q <= {wr_addr[9:5], wr_idx};
      if (wr_valid)
         mem_q[slot_q] <= wr_data;
   end
   // stored word for the fetch address
   assign rd_raw = mem_q[rd_addr[9:2]];
endmodule // flash_array_model

/* File: verif/flash_crypt_control_bench.sv */
`timescale 1ns/100ps
module flash_crypt_control_bench;
   logic clk = 0, rstn = 0, download_boot = 1, download_dis_encrypt = 1, op;
   logic download_dis_decrypt = 0, encrypt_path_enable = 1, decrypt_path_enable = 0;
   logic buf_we = 0, addr_we = 0, start = 0, wr_req = 0, rd_req = 0, done, wr_valid, rd_valid;
   logic [1:0] coding_scheme = 2'h1;
   logic [255:0] key_fuse_block;
   logic [3:0] flash_crypt_config = 4'h1;
   logic [6:0] flash_crypt_cnt = 7'h00;
   logic [2:0] buf_idx = 3'h0, wr_idx = 3'h0;
   logic [23:0] addr_wdata = 24'h0, wr_addr = 24'h0, rd_addr = 24'h0;
   logic [31:0] buf_wdata = 32'h0, wr_plain = 32'h0, wr_data, rd_raw, rd_data, d, c0, pt [8], ct [8];
   int mismatches = 0, n_checks = 0, i, k;
   // 125 MHz clock
   always #4 clk = ~clk;
   flash_crypt_control DUT (.*);
   flash_array_model u_flash (.*);
   // one comparison
   task chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // counts and verdict
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one flash write word or one cache fetch word
   task io(input logic w, input logic [23:0] a, input logic [31:0] p);
      @(posedge clk);
      {wr_req, rd_req, wr_addr, wr_idx, rd_addr, wr_plain} <= {w, !w, a, a[4:2], a, p};
      @(posedge clk);
      {wr_req, rd_req} <= 2'b00;
      @(negedge clk);
      chk("valid", w ? wr_valid : rd_valid, 1);
      d = w ? wr_data : rd_data;
   endtask
   // address, eight words lowest first, start, bounded wait for done
   task enc(input logic [23:0] a, input logic ok);
      @(posedge clk);
      {addr_we, addr_wdata} <= {1'b1, a};
      for (k = 0; k < 9; k++) begin
         @(posedge clk);
         {addr_we, buf_we, start, buf_idx, buf_wdata} <= {1'b0, k < 8, k == 8, k[2:0], pt[k % 8]};
      end
      @(posedge clk);
      start <= 0;
      // let a stale done from the last run drop before polling
      @(negedge clk);
      for (k = 0; k < 20 && done !== 1'b1; k++)
         @(negedge clk);
      chk("done", done, ok);
      if (ok && done !== 1'b1) finish_test;
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h3af1));
      key_fuse_block = {8{$urandom}};
      for (k = 0; k < 8; k++)
         pt[k] = $urandom;
      repeat (10) @(posedge clk);
      rstn <= 1;
      enc(24'h000100, 0);
      @(posedge clk);
      download_dis_encrypt <= 0;
      enc(24'h000100, 1);
      for (i = 0; i < 8; i++) begin
         io(1, {19'h00008, i[2:0], 2'h0}, ~pt[i]);
         ct[i] = d;
         chk("cipher", d === ~pt[i], 0);
      end
      io(1, 24'h000120, pt[0]);
      chk("plain", d, pt[0]);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         {download_boot, decrypt_path_enable, download_dis_decrypt} <= i[2:0];
         flash_crypt_cnt <= 7'($urandom);
         io(0, {19'h00008, i[2:0], 2'h0}, 32'h0);
         op = download_boot ? decrypt_path_enable & ~download_dis_decrypt : ^flash_crypt_cnt;
         chk("fetch", d, op ? pt[i] : ct[i]);
      end
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         flash_crypt_config <= i[0] ? 4'h3 : 4'h0;
         enc(24'h000100, 1);
         io(1, 24'h000100, 32'h0);
         c0 = d;
         enc(24'h000200, 1);
         io(1, 24'h000200, 32'h0);
         chk("addr_key", d === c0, i == 0);
      end
      finish_test;
   end
endmodule // flash_crypt_control_bench

/* File: verif/flash_crypt_sva.sv */
`timescale 1ns/100ps
// watches answers, write gating and done timing
module flash_crypt_sva #(parameter ROUNDS = 8) (
   input wire clk, rstn, download_boot, download_dis_encrypt, encrypt_path_enable,
   input wire start, done, wr_req, wr_valid, rd_req, rd_valid,
   input wire [31:0] wr_plain, wr_data
);
   reg run_q;
   wire op = encrypt_path_enable & ~(download_boot & download_dis_encrypt);
   wire go = start & op & ~run_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // an accepted start runs until done comes up
   always @(posedge clk or negedge rstn)
      if (!rstn)
         run_q <= 1'b0;
      else
         run_q <= go | (run_q & ~done);
   sequence s_rounds;
      !done [*7] ##[1:2] done;
   endsequence
   chk_done_time: assert property (go |=> s_rounds) else $error("done late");
   chk_done_hold: assert property (done && !go |=> done) else $error("done lost");
   chk_refused: assert property (start && !op && !run_q && !done |=> !done)
      else $error("refused start ran");
   chk_wr_answer: assert property (wr_req |=> wr_valid) else $error("no wr answer");
   chk_wr_pulse: assert property (wr_valid |-> $past(wr_req)) else $error("stray wr");
   chk_plain: assert property (wr_req && !op |=> wr_data == $past(wr_plain))
      else $error("wr data changed");
   chk_rd_answer: assert property (rd_req |=> rd_valid) else $error("no rd answer");
   chk_rd_pulse: assert property (rd_valid |-> $past(rd_req)) else $error("stray rd");
endmodule // flash_crypt_sva
bind flash_crypt_control flash_crypt_sva #(.ROUNDS(ROUNDS)) u_sva (.*);
